// ==== design/gdc_gate_drive_control.sv ====
// Digital control of a three-phase half-bridge gate driver
//
// Contract
// RL1: Trickle charge only while low input low
// RL2: Always-on setting forces trickle charging
// RL3: Supply-low flag set at power-up, latched
// RL4: Fault clear command clears supply-low flag
// RL5: Strong pulldown on opposite gate after switching
// RL6: Sleep activates low-side semi-active pulldown
// RL7: Six-input both-high drives low, flags fault
// RL8: Six-input monitored dead time when gap short
// RL9: Other modes always insert dead time
// RL10: Nine-step gain field, 5 to 40
// RL11: Offset select half or eighth reference
// RL12: Sense amps disabled until enable bit set
// RL13: Controller waits 100 us before sampling
// RL14: Fault or hard disable pulls gates down
// RL15: Hard disable high overrides PWM inputs
// RL16: Hard disable reaches gates unclocked
// RL17: Shutdown initial current then programmed current
// RL18: After shutdown, gates semi-active pulldown
// RL19: Shutdown sink current field selects phase two
// RL20: Six-input truth table for gate outputs
// RL21: Dead time and shutdown are clock counters
// RL22: Shoot-through fault latched until clear
`timescale 1ns/1ns
`include "gdc_defs.svh"
module gdc_gate_drive_control #(
    parameter logic [7:0] DEAD_CYC = `GDC_DEAD_CYC,
    parameter logic [7:0] STRONG_CYC = `GDC_STRONG_CYC,
    parameter logic [11:0] SD_INIT_CYC = `GDC_SD_INIT_CYC,
    parameter logic [11:0] SD_TOTAL_CYC = `GDC_SD_TOTAL_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire gdc_pkg::gdc_pwm_t [2:0] pwm_in,
    input wire logic [1:0] pwm_mode,
    input wire logic dead_time_policy,
    input wire logic [1:0] six_input_dead_time_select,
    input wire logic trickle_charge_always_on,
    input wire logic fault_clear_command,
    input wire logic fault_in,
    input wire logic hard_disable_pin,
    input wire logic sleep_mode,
    input wire logic sense_amp_enable_wr,
    input wire logic sense_amp_enable_data,
    input wire logic [3:0] sense_amp_gain_wr_data,
    input wire logic sense_amp_gain_wr,
    input wire logic sense_amp_offset_eighth_in,
    input wire logic [3:0] shutdown_sink_current_setting,
    output logic [2:0] high_gate_out_x,
    output logic [2:0] low_gate_out_x,
    output logic [2:0] bootstrap_node_x,
    output logic [2:0] strong_pd_high,
    output logic [2:0] strong_pd_low,
    output logic [2:0] semi_pd_low,
    output logic [2:0] semi_pd_high,
    output logic overdrive_supply_low_flag,
    output logic shoot_through_fault,
    output logic sense_amp_enable,
    output logic [3:0] sense_amp_gain,
    output logic sense_amp_offset_eighth,
    output logic sd_active,
    output logic sd_use_initial,
    output logic [3:0] sd_sink_current
);
    // Dead time needed when six-input monitor is on, or in any other mode
    wire dt_mon = (pwm_mode == `GDC_MODE_6X) && (dead_time_policy == `GDC_DT_POLICY_MON)
        && (six_input_dead_time_select == `GDC_DT_6X_MON);
    wire dt_always = (pwm_mode != `GDC_MODE_6X); // [RL9]
    wire [2:0] both_hi;
    wire [2:0] req_hi;
    wire [2:0] req_lo;
    logic [2:0] gh_q; // Registered gate commands
    logic [2:0] gl_q;
    logic [7:0] dt_cnt [2:0]; // Cycles since both gates were off
    logic [7:0] spd_cnt [2:0]; // Strong pulldown windows
    logic [2:0] spd_hi_side; // Which gate gets strong pulldown
    gdc_pkg::gdc_sd_t sd_state;
    gdc_pkg::gdc_sd_t next_sd_state;
    logic [11:0] sd_cnt;
    logic sd_latched; // Sequence already run for the present request
    wire sd_req = hard_disable_pin | fault_in; // [RL14]
    // Saturating increment, used by the dead-time counter
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == 8'hff) ? v : v + 8'h01;
    endfunction : sat_inc
    // Per-phase request decode and dead-time gating
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_ph
            assign both_hi[g] = pwm_in[g].hi & pwm_in[g].lo; // [RL7]
            // Truth table: a gate turns on only when its own input alone is high
            assign req_hi[g] = pwm_in[g].hi & ~pwm_in[g].lo; // [RL20]
            assign req_lo[g] = pwm_in[g].lo & ~pwm_in[g].hi; // [RL20]
            // Opposing gate must have been off for the dead time first
            wire dt_ok = !(dt_mon || dt_always) || (dt_cnt[g] >= DEAD_CYC); // [RL8] [RL9]
            // Gate outputs: hard disable gates the clocked command with no flop
            assign high_gate_out_x[g] = gh_q[g] & ~hard_disable_pin & ~sd_active; // [RL15] [RL16]
            assign low_gate_out_x[g] = gl_q[g] & ~hard_disable_pin & ~sd_active; // [RL15] [RL16]
            // Trickle charge while low input idle or forced on
            assign bootstrap_node_x[g] = trickle_charge_always_on | ~pwm_in[g].lo; // [RL1] [RL2]
            assign strong_pd_high[g] = (spd_cnt[g] != 8'h00) & spd_hi_side[g];
            assign strong_pd_low[g] = (spd_cnt[g] != 8'h00) & ~spd_hi_side[g];
            // Gate command register with dead-time counting
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    gh_q[g] <= 1'b0;
                    gl_q[g] <= 1'b0;
                    dt_cnt[g] <= 8'h00;
                end
                else if (clk_en)
                begin
                    // Counter advances only while both gates are off
                    dt_cnt[g] <= (gh_q[g] | gl_q[g]) ? 8'h00 : sat_inc(dt_cnt[g]); // [RL21]
                    if (sd_active)
                    begin
                        gh_q[g] <= 1'b0;
                        gl_q[g] <= 1'b0;
                    end
                    else if (gh_q[g] | gl_q[g])
                    begin
                        // Turn off immediately when the request drops
                        gh_q[g] <= gh_q[g] & req_hi[g];
                        gl_q[g] <= gl_q[g] & req_lo[g];
                    end
                    else if (dt_ok)
                    begin
                        gh_q[g] <= req_hi[g];
                        gl_q[g] <= req_lo[g];
                    end
                end
            end
            // Strong pulldown window on the opposite gate at each switch
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    spd_cnt[g] <= 8'h00;
                    spd_hi_side[g] <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (next_gh(g) != gh_q[g])
                    begin
                        spd_cnt[g] <= STRONG_CYC; // [RL5]
                        spd_hi_side[g] <= 1'b0;
                    end
                    else if (next_gl(g) != gl_q[g])
                    begin
                        spd_cnt[g] <= STRONG_CYC; // [RL5]
                        spd_hi_side[g] <= 1'b1;
                    end
                    else if (spd_cnt[g] != 8'h00)
                        spd_cnt[g] <= spd_cnt[g] - 8'h01;
                end
            end
        end
    endgenerate
    // Next gate commands as the gate registers compute them
    function automatic logic next_gh(input int i);
        if (sd_active)
            next_gh = 1'b0;
        else if (gh_q[i] | gl_q[i])
            next_gh = gh_q[i] & req_hi[i];
        else
            next_gh = req_hi[i] & (!(dt_mon || dt_always) || (dt_cnt[i] >= DEAD_CYC));
    endfunction : next_gh
    function automatic logic next_gl(input int i);
        if (sd_active)
            next_gl = 1'b0;
        else if (gh_q[i] | gl_q[i])
            next_gl = gl_q[i] & req_lo[i];
        else
            next_gl = req_lo[i] & (!(dt_mon || dt_always) || (dt_cnt[i] >= DEAD_CYC));
    endfunction : next_gl
    // Semi-active pulldown: low side in sleep, all gates after shutdown
    // Only after a finished sequence, not in the cycle a request first rises
    wire sd_done = (sd_state == gdc_pkg::GDC_RUN) & sd_latched & sd_req;
    assign semi_pd_low = {3{sleep_mode | sd_done}}; // [RL6] [RL18]
    assign semi_pd_high = {3{sd_done}}; // [RL18]
    assign sd_active = (sd_state != gdc_pkg::GDC_RUN) | sd_req; // [RL14]
    assign sd_use_initial = (sd_state == gdc_pkg::GDC_SD_INIT); // [RL17]
    assign sd_sink_current = sd_use_initial ? 4'h0 : shutdown_sink_current_setting; // [RL19]
    // Shutdown sequencer next state
    always_comb
    begin
        next_sd_state = sd_state;
        case (sd_state)
            gdc_pkg::GDC_RUN:
                if (sd_req && !sd_latched) next_sd_state = gdc_pkg::GDC_SD_INIT;
            gdc_pkg::GDC_SD_INIT:
                if (sd_cnt >= SD_INIT_CYC - 12'h001) next_sd_state = gdc_pkg::GDC_SD_HOLD; // [RL17]
            gdc_pkg::GDC_SD_HOLD:
                if (sd_cnt >= SD_TOTAL_CYC - 12'h001) next_sd_state = gdc_pkg::GDC_RUN; // [RL17]
            default:
                next_sd_state = gdc_pkg::GDC_RUN;
        endcase
    end
    // Sequence runs once per assertion of the shutdown request
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sd_state <= gdc_pkg::GDC_RUN;
            sd_cnt <= 12'h000;
            sd_latched <= 1'b0;
        end
        else if (clk_en)
        begin
            sd_state <= next_sd_state;
            // Zero in the first shutdown cycle, so each phase lasts its full count
            sd_cnt <= (sd_state == gdc_pkg::GDC_RUN) ? 12'h000 : sd_cnt + 12'h001; // [RL21]
            sd_latched <= sd_req & (sd_latched | (sd_state != gdc_pkg::GDC_RUN));
        end
    end
    // Latched flags; a new event wins over a clear in the same cycle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            overdrive_supply_low_flag <= 1'b1; // [RL3]
            shoot_through_fault <= 1'b0;
        end
        else if (clk_en)
        begin
            if (fault_clear_command)
                overdrive_supply_low_flag <= 1'b0; // [RL4]
            if ((pwm_mode == `GDC_MODE_6X) && (|both_hi))
                shoot_through_fault <= 1'b1; // [RL7] [RL22]
            else if (fault_clear_command)
                shoot_through_fault <= 1'b0; // [RL22]
        end
    end
    // Sense amplifier settings; gain codes above the top step are ignored
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sense_amp_enable <= 1'b0; // [RL12]
            sense_amp_gain <= 4'h0;
            sense_amp_offset_eighth <= 1'b0;
        end
        else if (clk_en)
        begin
            if (sense_amp_enable_wr)
                sense_amp_enable <= sense_amp_enable_data; // [RL12]
            if (sense_amp_gain_wr && sense_amp_gain_wr_data <= `GDC_GAIN_MAX)
                sense_amp_gain <= sense_amp_gain_wr_data; // [RL10]
            sense_amp_offset_eighth <= sense_amp_offset_eighth_in; // [RL11]
        end
    end
    // The controller's 100 us settling wait is its own duty [RL13]
    a_gates_off_disable: assert property (@(posedge mclk) disable iff (rst)
        hard_disable_pin |-> (high_gate_out_x == 3'h0 && low_gate_out_x == 3'h0)) // [RL15]
        else $error("gate on during hard disable");
    a_no_both_on: assert property (@(posedge mclk) disable iff (rst)
        !(|(high_gate_out_x & low_gate_out_x))) // [RL7]
        else $error("both gates on");
    a_st_fault_set: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && pwm_mode == `GDC_MODE_6X && |both_hi) |=> shoot_through_fault) // [RL22]
        else $error("shoot-through not flagged");
    a_ovd_clear: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && fault_clear_command) |=> !overdrive_supply_low_flag) // [RL4]
        else $error("supply flag not cleared");
    a_sd_init_phase: assert property (@(posedge mclk) disable iff (rst)
        ($rose(sd_use_initial)) |-> sd_sink_current == 4'h0) // [RL17]
        else $error("initial current not used");
    a_trickle_gate: assert property (@(posedge mclk) disable iff (rst)
        (!trickle_charge_always_on && pwm_in[0].lo) |-> !bootstrap_node_x[0]) // [RL1]
        else $error("trickle on while low input high");
    a_csa_enable: assert property (@(posedge mclk) disable iff (rst)
        $rose(sense_amp_enable) |-> $past(sense_amp_enable_wr)) // [RL12]
        else $error("sense amp enabled without write");
    a_gain_range: assert property (@(posedge mclk) disable iff (rst)
        sense_amp_gain <= `GDC_GAIN_MAX) // [RL10]
        else $error("gain out of range");
endmodule : gdc_gate_drive_control

// ==== design/gdc_defs.svh ====
// Constants for the gate drive control block
`ifndef GDC_DEFS_SVH
`define GDC_DEFS_SVH
// Mode encodings of the PWM mode field
`define GDC_MODE_6X 2'h0
`define GDC_MODE_3X 2'h1
`define GDC_MODE_1X 2'h2
`define GDC_MODE_IND 2'h3
// Dead-time policy and six-input select values that enable monitored insertion
`define GDC_DT_POLICY_MON 1'h0
`define GDC_DT_6X_MON 2'h0
// Sense amplifier gain code range (nine settings, 5 to 40 V/V)
`define GDC_GAIN_MAX 4'h8
// Default timing counts in mclk cycles (8 ns)
`define GDC_DEAD_CYC 8'h0c
`define GDC_STRONG_CYC 8'h20
`define GDC_SD_INIT_CYC 12'h020
`define GDC_SD_TOTAL_CYC 12'h200
// Controller-side wait after sense amplifier enable
`define GDC_CSA_WAIT_US 100
`define GDC_CSA_WAIT_CYC ((`GDC_CSA_WAIT_US * 1000) / 8)
`endif

// ==== design/gdc_pkg.sv ====
// Types for the gate drive control block
package gdc_pkg;
    // Per-phase PWM input pair
    typedef struct packed {
        logic hi;
        logic lo;
    } gdc_pwm_t;
    // Shutdown sequencer states, one-hot
    typedef enum logic [2:0] {
        GDC_RUN = 3'b001,
        GDC_SD_INIT = 3'b010,
        GDC_SD_HOLD = 3'b100
    } gdc_sd_t;
endpackage : gdc_pkg

// ==== testbench/gdc_ctrl_model.sv ====
// Controller model that drives the PWM inputs and times sense amplifier sampling
`timescale 1ns/1ns
module gdc_ctrl_model #(
    parameter int WAIT_CYC = 50
) (
    mclk,
    rst,
    sense_amp_enable,
    pwm_in,
    sample_ok
);
    input wire logic mclk;
    input wire logic rst;
    input wire logic sense_amp_enable;
    output gdc_pkg::gdc_pwm_t [2:0] pwm_in;
    output logic sample_ok;
    // Cycles since the amplifiers came on
    int wait_count;
    // Idle inputs so no gate is requested out of reset
    initial pwm_in = '0;
    // Count from enable; a drop of enable restarts the wait
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            wait_count <= 0;
        else if (!sense_amp_enable)
            wait_count <= 0;
        else if (wait_count < WAIT_CYC)
            wait_count <= wait_count + 1;
    end
    // No sampling until the settling wait is over
    assign sample_ok = (wait_count >= WAIT_CYC);
    // Inputs change just after a falling edge, well clear of sampling
    task automatic drive(input int ph, input logic hi, input logic lo);
        @(negedge mclk);
        pwm_in[ph] = '{hi: hi, lo: lo};
    endtask : drive
endmodule : gdc_ctrl_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the gate drive control block
`timescale 1ns/1ns
`include "gdc_defs.svh"
module tb_top;
    // Short counts keep the run brief
    localparam int DEAD = 2;
    localparam int STRONG = 3;
    localparam int SD_INIT = 4;
    localparam int SD_TOTAL = 10;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] pwm_mode = 2'h0;
    logic dead_time_policy = 1'b0;
    logic [1:0] six_input_dead_time_select = 2'h0;
    logic trickle_charge_always_on = 1'b0;
    logic clk_en = 1'b1;
    logic fault_clear_command = 1'b0, fault_in = 1'b0, hard_disable_pin = 1'b0, sleep_mode = 1'b0;
    logic sense_amp_enable_wr = 1'b0, sense_amp_enable_data = 1'b0, sense_amp_gain_wr = 1'b0;
    logic [3:0] sense_amp_gain_wr_data = 4'h0;
    logic sense_amp_offset_eighth_in = 1'b0;
    logic [3:0] shutdown_sink_current_setting = 4'ha;
    gdc_pkg::gdc_pwm_t [2:0] pwm_in;
    logic [2:0] hg, lg, bs, spd_h, spd_l, semi_l, semi_h;
    logic ov_flag, st_fault, csa_en, csa_off, sd_active, sd_init, sample_ok;
    logic [3:0] csa_gain, sd_cur;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    // Half period of 4 ns for 125 MHz
    always #4 mclk = ~mclk;
    gdc_gate_drive_control #(.DEAD_CYC(8'h02), .STRONG_CYC(8'h03), .SD_INIT_CYC(12'h004),
        .SD_TOTAL_CYC(12'h00a)) i_gdc_gate_drive_control (.mclk(mclk), .rst(rst), .clk_en(clk_en),
        .pwm_in(pwm_in), .pwm_mode(pwm_mode), .dead_time_policy(dead_time_policy),
        .six_input_dead_time_select(six_input_dead_time_select),
        .trickle_charge_always_on(trickle_charge_always_on), .fault_clear_command(fault_clear_command),
        .fault_in(fault_in), .hard_disable_pin(hard_disable_pin), .sleep_mode(sleep_mode),
        .sense_amp_enable_wr(sense_amp_enable_wr), .sense_amp_enable_data(sense_amp_enable_data),
        .sense_amp_gain_wr_data(sense_amp_gain_wr_data), .sense_amp_gain_wr(sense_amp_gain_wr),
        .sense_amp_offset_eighth_in(sense_amp_offset_eighth_in),
        .shutdown_sink_current_setting(shutdown_sink_current_setting), .high_gate_out_x(hg),
        .low_gate_out_x(lg), .bootstrap_node_x(bs), .strong_pd_high(spd_h), .strong_pd_low(spd_l),
        .semi_pd_low(semi_l), .semi_pd_high(semi_h), .overdrive_supply_low_flag(ov_flag),
        .shoot_through_fault(st_fault), .sense_amp_enable(csa_en), .sense_amp_gain(csa_gain),
        .sense_amp_offset_eighth(csa_off), .sd_active(sd_active), .sd_use_initial(sd_init),
        .sd_sink_current(sd_cur));
    gdc_ctrl_model #(.WAIT_CYC(`GDC_CSA_WAIT_CYC)) i_gdc_ctrl_model (.mclk(mclk), .rst(rst),
        .sense_amp_enable(csa_en), .pwm_in(pwm_in), .sample_ok(sample_ok));
    // Cuts a hang short well past the expected run length
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    // One comparison, case-equal so unknowns fail
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Wait n falling edges; inputs then change away from sampling
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask : step
    // One-cycle strobe on a pulse input
    task automatic pulse(ref logic s);
        @(negedge mclk);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask : pulse
    // Counts, verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial
    begin
        step(8);
        rst = 1'b0;
        step(1);
        chk("ov_flag", 4'h1, {3'h0, ov_flag});
        chk("csa_en", 4'h0, {3'h0, csa_en});
        chk("bootstrap", 4'h7, {1'b0, bs});
        i_gdc_ctrl_model.drive(0, 1'b0, 1'b1);
        step(1);
        chk("bootstrap", 4'h6, {1'b0, bs});
        trickle_charge_always_on = 1'b1;
        step(1);
        chk("bootstrap", 4'h7, {1'b0, bs});
        trickle_charge_always_on = 1'b0;
        i_gdc_ctrl_model.drive(0, 1'b0, 1'b0);
        pulse(fault_clear_command);
        step(1);
        chk("ov_flag", 4'h0, {3'h0, ov_flag});
        $display("test reset_trickle done");
        sense_amp_gain_wr_data = 4'h8;
        pulse(sense_amp_gain_wr);
        sense_amp_gain_wr_data = 4'h9;
        pulse(sense_amp_gain_wr);
        sense_amp_offset_eighth_in = 1'b1;
        sense_amp_enable_data = 1'b1;
        pulse(sense_amp_enable_wr);
        step(1);
        chk("gain", 4'h8, csa_gain);
        chk("offset", 4'h1, {3'h0, csa_off});
        chk("csa_en", 4'h1, {3'h0, csa_en});
        step(`GDC_CSA_WAIT_CYC - 2);
        chk("sample_ok", 4'h0, {3'h0, sample_ok});
        step(2);
        chk("sample_ok", 4'h1, {3'h0, sample_ok});
        $display("test sense_amp done");
        i_gdc_ctrl_model.drive(0, 1'b1, 1'b0);
        step(2);
        chk("high_gate", 4'h1, {1'b0, hg});
        chk("strong_pd_low", 4'h1, {1'b0, spd_l});
        step(STRONG + 1);
        chk("strong_pd_low", 4'h0, {1'b0, spd_l});
        i_gdc_ctrl_model.drive(0, 1'b0, 1'b1);
        step(3);
        chk("low_gate", 4'h0, {1'b0, lg});
        step(DEAD + 1);
        chk("low_gate", 4'h1, {1'b0, lg});
        chk("strong_pd_high", 4'h1, {1'b0, spd_h});
        i_gdc_ctrl_model.drive(0, 1'b1, 1'b1);
        step(2);
        chk("gates", 4'h0, {1'b0, hg | lg});
        chk("st_fault", 4'h1, {3'h0, st_fault});
        i_gdc_ctrl_model.drive(0, 1'b0, 1'b0);
        step(2);
        chk("st_fault", 4'h1, {3'h0, st_fault});
        pulse(fault_clear_command);
        step(1);
        chk("st_fault", 4'h0, {3'h0, st_fault});
        $display("test six_input done");
        i_gdc_ctrl_model.drive(1, 1'b1, 1'b0);
        step(DEAD + 3);
        chk("high_gate", 4'h2, {1'b0, hg});
        fault_in = 1'b1;
        step(2);
        chk("high_gate", 4'h0, {1'b0, hg});
        chk("sd_active", 4'h1, {3'h0, sd_active});
        fault_in = 1'b0;
        i_gdc_ctrl_model.drive(1, 1'b0, 1'b0);
        step(SD_TOTAL + 4);
        i_gdc_ctrl_model.drive(2, 1'b1, 1'b0);
        step(DEAD + 3);
        chk("high_gate", 4'h4, {1'b0, hg});
        hard_disable_pin = 1'b1;
        #1;
        chk("high_gate", 4'h0, {1'b0, hg});
        chk("semi_pd_high", 4'h0, {1'b0, semi_h});
        step(1);
        chk("sd_init", 4'h1, {3'h0, sd_init});
        chk("sd_cur", 4'h0, sd_cur);
        step(SD_INIT - 1);
        chk("sd_init", 4'h1, {3'h0, sd_init});
        step(2);
        chk("sd_cur", 4'ha, sd_cur);
        step(SD_TOTAL - SD_INIT - 2);
        chk("semi_pd_high", 4'h0, {1'b0, semi_h});
        step(2);
        chk("semi_pd_high", 4'h7, {1'b0, semi_h});
        chk("high_gate", 4'h0, {1'b0, hg});
        hard_disable_pin = 1'b0;
        i_gdc_ctrl_model.drive(2, 1'b0, 1'b0);
        sleep_mode = 1'b1;
        step(2);
        chk("semi_pd_low", 4'h7, {1'b0, semi_l});
        $display("test shutdown done");
        // Three-input mode inserts dead time whatever the policy
        sleep_mode = 1'b0;
        pwm_mode = 2'h1;
        dead_time_policy = 1'b1;
        i_gdc_ctrl_model.drive(2, 1'b1, 1'b0);
        step(3);
        i_gdc_ctrl_model.drive(2, 1'b0, 1'b1);
        step(3);
        chk("low_gate", 4'h0, {1'b0, lg});
        step(3);
        chk("low_gate", 4'h4, {1'b0, lg});
        // Six-input mode with the monitor off switches after a one-cycle gap, with no dead time
        pwm_mode = 2'h0;
        i_gdc_ctrl_model.drive(2, 1'b1, 1'b0);
        step(2);
        chk("high_gate", 4'h4, {1'b0, hg});
        // Clock enable low freezes the settings
        clk_en = 1'b0;
        sense_amp_gain_wr_data = 4'h3;
        pulse(sense_amp_gain_wr);
        step(1);
        chk("gain", 4'h8, csa_gain);
        clk_en = 1'b1;
        pulse(sense_amp_gain_wr);
        step(1);
        chk("gain", 4'h3, csa_gain);
        $display("test modes done");
        report_and_stop();
    end
endmodule : tb_top
